// [rtl/afe_config_adc_control.sv]
// Front-end configuration and conversion sequencer
`timescale 1ns/1ps

// How it works
// R1: Core rate selects 1 MHz or 3.33 MHz (10 MHz divided by 10 or 3), derived as enable pulses.
// R2: Bridge gain code comes from bridge word bits 6 to 4.
// R3: Temperature gain code comes from temperature word bits 6 to 4.
// R4: Gain code maps to gains 1.5 through 192 per fixed table.
// R5: Bit 7 sets gain sign; zero inverts via chopper phase flip.
// R6: Bit 12 set skips the nulling phase before conversion.
// R7: Software should enable nulling only for gains of six or more.
// R8: Normal conversion is 9 coarse bits then 5 fine bits.
// R9: A coarse conversion lasts four chopper periods.
// R10: Long integration quadruples coarse time, 11 coarse plus 3 fine bits.
// R11: Auto-zero reading taken periodically and subtracted from every result.
// R12: Bridge range shift code comes from bridge word bits 3 to 0.
// R13: Shift code n gives expected zero count of n times 1024.
// R14: Raw bridge output needs offset coefficient (code minus 8) times 0x400.
// R15: Software must not use shift code zero for bridge measurements.
// R16: Software should keep the temperature shift code as trimmed.
// R17: Result equals sensor count minus auto-zero count, signed.
// R18: Temperature result scaling uses fixed gain six.
// R19: Two-wire port serves calibration; four-wire only in application.
// R20: Matching word loads into active configuration before each measurement.
// R21: Long integration bit sits at bit 8 of each word.
// R22: Bridge sink switch on a settle time before conversion, off after.
// R23: Unassigned configuration bits have no effect.
// R24: Sequence: load, optional null, coarse, fine, then one result.
module afe_config_adc_control #(
  parameter int CHOP_TICKS_P = afe_ctrl_pkg::CHOP_TICKS,
  parameter int NULL_TICKS_P = afe_ctrl_pkg::NULL_TICKS,
  parameter int AZ_EVERY_P   = 4
) (
  // Clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_n,
  // Configuration word port
  input  wire logic                          i_cfg_wr,
  input  wire logic                          i_cfg_rd,
  input  wire logic [afe_ctrl_pkg::ADDR_W-1:0] i_cfg_addr,
  input  wire logic [afe_ctrl_pkg::CFG_W-1:0]  i_cfg_wdata,
  output logic      [afe_ctrl_pkg::CFG_W-1:0]  o_cfg_rdata,
  // Mode selection
  input  wire logic                          i_fast_clk,
  input  wire logic                          i_two_wire,
  input  wire logic                          i_calib_mode,
  // Measurement request
  input  wire logic                          i_start,
  input  wire logic                          i_temp_sel,
  // Comparator bit from the converter
  input  wire logic                          i_adc_bit,
  // Front-end control
  output logic      [2:0]                    o_amp_gain_code,
  output logic      [3:0]                    o_range_shift_code,
  output logic                               o_chop_phase,
  output logic                               o_null_en,
  output logic                               o_integrate,
  output logic                               o_fine_en,
  output logic                               o_input_short,
  output logic                               o_bridge_sink_on,
  output logic                               o_four_wire_en,
  // Result
  output logic signed [afe_ctrl_pkg::RES_W:0] o_result,
  output logic      [afe_ctrl_pkg::RES_W-1:0] o_zero_count,
  output logic      [8:0]                    o_gain_x2,
  output logic                               o_result_temp,
  output logic                               o_result_valid,
  output logic                               o_busy
);
  import afe_ctrl_pkg::*;

  // ****************************************
  // Configuration words
  // ****************************************
  logic [CFG_W-1:0] bridge_cfg_r;
  logic [CFG_W-1:0] temp_cfg_r;
  logic [CFG_W-1:0] active_cfg_r;
  logic             active_temp_r;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bridge_cfg_r <= BRIDGE_CFG_RST;
      temp_cfg_r   <= TEMP_CFG_RST;
    end else if (i_cfg_wr) begin
      if (i_cfg_addr == BRIDGE_CFG_ADDR) begin
        bridge_cfg_r <= i_cfg_wdata;
      end
      if (i_cfg_addr == TEMP_CFG_ADDR) begin
        temp_cfg_r <= i_cfg_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= '0;
    end else if (i_cfg_rd) begin
      case (i_cfg_addr)
        BRIDGE_CFG_ADDR: o_cfg_rdata <= bridge_cfg_r;
        TEMP_CFG_ADDR:   o_cfg_rdata <= temp_cfg_r;
        default:         o_cfg_rdata <= '0;
      endcase
    end
  end

  // ****************************************
  // Core rate enable
  // ****************************************
  logic [3:0] div_cnt_r;
  logic       tick;
  logic [3:0] div_max;

  assign div_max = i_fast_clk ? 4'(DIV_4MHZ - 1) : 4'(DIV_1MHZ - 1);
  assign tick    = (div_cnt_r >= div_max);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt_r <= '0;
    end else if (tick) begin
      div_cnt_r <= '0; // R1
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] coarse_ticks(input logic long_int,
                                               input int chop);
    int n;
    n = CHOP_PER_CONV * chop; // R9
    if (long_int) begin
      n = n * LONG_FACTOR; // R10
    end
    return 16'(n);
  endfunction

  function automatic logic [3:0] fine_bits(input logic long_int);
    return long_int ? 4'(RES_W - COARSE_LONG) : 4'(RES_W - COARSE_NORM); // R8
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  seq_state_t       state_r;
  logic [15:0]      cnt_r;
  logic [RES_W-1:0] acc_r;
  logic [3:0]       fine_left_r;
  logic             az_pass_r;
  logic [7:0]       meas_cnt_r;
  logic             req_temp_r;
  logic             long_int;
  logic             null_off;
  logic [15:0]      settle_cyc;

  assign long_int   = active_cfg_r[LONGINT_BIT]; // R21
  assign null_off   = active_cfg_r[NULL_DIS_BIT]; // R6
  assign settle_cyc = i_fast_clk ? 16'(SETTLE_4MHZ_CYC) :
                                   16'(SETTLE_1MHZ_CYC);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r      <= ST_IDLE;
      cnt_r        <= '0;
      acc_r        <= '0;
      fine_left_r  <= '0;
      active_cfg_r <= '0;
      active_temp_r <= 1'b0;
      req_temp_r   <= 1'b0;
      az_pass_r    <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (i_start) begin
            req_temp_r <= i_temp_sel;
            state_r    <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Copy word before measurement
          active_cfg_r  <= req_temp_r ? temp_cfg_r : bridge_cfg_r; // R20
          active_temp_r <= req_temp_r;
          cnt_r         <= '0;
          state_r       <= ST_SETTLE;
        end
        ST_SETTLE: begin
          if (cnt_r >= settle_cyc - 16'h1) begin // R22
            cnt_r   <= '0;
            state_r <= null_off ? ST_COARSE : ST_NULL; // R6
          end else begin
            cnt_r <= cnt_r + 16'h1;
          end
        end
        ST_NULL: begin
          if (tick) begin
            if (cnt_r >= 16'(NULL_TICKS_P - 1)) begin
              cnt_r   <= '0;
              state_r <= ST_COARSE; // R24
            end else begin
              cnt_r <= cnt_r + 16'h1;
            end
          end
        end
        ST_COARSE: begin
          if (tick) begin
            if (i_adc_bit) begin
              acc_r <= acc_r + RES_W'(1 << fine_bits(long_int));
            end
            if (cnt_r >= coarse_ticks(long_int, CHOP_TICKS_P) - 16'h1) begin
              cnt_r       <= '0;
              fine_left_r <= fine_bits(long_int);
              state_r     <= ST_FINE; // R24
            end else begin
              cnt_r <= cnt_r + 16'h1;
            end
          end
        end
        ST_FINE: begin
          if (tick) begin
            fine_left_r <= fine_left_r - 4'h1;
            if (i_adc_bit) begin
              acc_r <= acc_r | RES_W'(1 << (fine_left_r - 4'h1));
            end
            if (fine_left_r == 4'h1) begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          acc_r     <= '0;
          az_pass_r <= (meas_cnt_r == 8'(AZ_EVERY_P - 1)) && !az_pass_r; // R11
          state_r   <= az_pass_r ? ST_LOAD : ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Auto-zero bookkeeping and result
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meas_cnt_r <= '0;
    end else if (state_r == ST_DONE && !az_pass_r) begin
      meas_cnt_r <= (meas_cnt_r == 8'(AZ_EVERY_P - 1)) ? 8'h0 :
                    meas_cnt_r + 8'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero_count   <= '0;
      o_result       <= '0;
      o_result_valid <= 1'b0;
      o_result_temp  <= 1'b0;
    end else begin
      o_result_valid <= 1'b0;
      if (state_r == ST_DONE) begin
        if (az_pass_r) begin
          o_zero_count <= acc_r; // R11
        end else begin
          o_result <= $signed({1'b0, acc_r}) -
                      $signed({1'b0, o_zero_count}); // R17
          o_result_temp  <= active_temp_r;
          o_result_valid <= 1'b1; // R24
        end
      end
    end
  end

  // ****************************************
  // Front-end control outputs
  // ****************************************
  logic [8:0] gain_x2;

  afe_gain_decode u_gain (
    .i_gain_code_bits (active_cfg_r[GAIN_LSB +: GAIN_W]),
    .i_is_temp        (active_temp_r),
    .o_gain_x2        (gain_x2)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_amp_gain_code    <= '0;
      o_range_shift_code <= '0;
      o_chop_phase       <= 1'b0;
      o_null_en          <= 1'b0;
      o_integrate        <= 1'b0;
      o_fine_en          <= 1'b0;
      o_input_short      <= 1'b0;
      o_bridge_sink_on   <= 1'b0;
      o_gain_x2          <= '0;
      o_busy             <= 1'b0;
      o_four_wire_en     <= 1'b0;
    end else begin
      // Only documented fields reach the front end
      o_amp_gain_code    <= active_cfg_r[GAIN_LSB +: GAIN_W]; // R2 R3 R23
      o_range_shift_code <= active_cfg_r[SHIFT_LSB +: SHIFT_W]; // R12 R13
      o_chop_phase       <= ~active_cfg_r[POL_BIT]; // R5
      o_null_en          <= (state_r == ST_NULL);
      o_integrate        <= (state_r == ST_COARSE);
      o_fine_en          <= (state_r == ST_FINE);
      o_input_short      <= az_pass_r && (state_r != ST_IDLE);
      o_bridge_sink_on   <= (state_r == ST_SETTLE) || (state_r == ST_NULL) ||
                            (state_r == ST_COARSE) || (state_r == ST_FINE); // R22
      o_gain_x2          <= gain_x2; // R18
      o_busy             <= (state_r != ST_IDLE);
      o_four_wire_en     <= !i_two_wire && !i_calib_mode; // R19
    end
  end
endmodule

// [rtl/afe_ctrl_pkg.sv]
// Package of constants for the front-end configuration and conversion control
package afe_ctrl_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [4:0] BRIDGE_CFG_ADDR = 5'h0f;
  localparam logic [4:0] TEMP_CFG_ADDR   = 5'h10;
  localparam int         CFG_W           = 16;
  localparam int         ADDR_W          = 5;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SHIFT_LSB    = 0;
  localparam int SHIFT_W      = 4;
  localparam int GAIN_LSB     = 4;
  localparam int GAIN_W       = 3;
  localparam int POL_BIT      = 7;
  localparam int LONGINT_BIT  = 8;
  localparam int NULL_DIS_BIT = 12;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] BRIDGE_CFG_RST = 16'h0088;
  localparam logic [15:0] TEMP_CFG_RST   = 16'h0010;

  // ****************************************
  // Conversion shape
  // ****************************************
  localparam int RES_W         = 14;
  localparam int COARSE_NORM   = 9;
  localparam int COARSE_LONG   = 11;
  localparam int CHOP_PER_CONV = 4;
  localparam int LONG_FACTOR   = 4;
  localparam int ZERO_STEP     = 1024;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ       = 10_000_000;
  localparam int CORE_1MHZ        = 1_000_000;
  localparam int CORE_4MHZ        = 4_000_000;
  localparam int SETTLE_1MHZ_US   = 190;
  localparam int SETTLE_4MHZ_US   = 50;
  localparam int SETTLE_1MHZ_CYC  = (SETTLE_1MHZ_US * (SYS_CLK_HZ / 1000)) / 1000;
  localparam int SETTLE_4MHZ_CYC  = (SETTLE_4MHZ_US * (SYS_CLK_HZ / 1000)) / 1000;
  localparam int DIV_1MHZ         = SYS_CLK_HZ / CORE_1MHZ;
  localparam int DIV_4MHZ         = (SYS_CLK_HZ + CORE_4MHZ - 1) / CORE_4MHZ;
  localparam int CHOP_TICKS       = 16;
  localparam int NULL_TICKS       = 32;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b000_0001,
    ST_LOAD   = 7'b000_0010,
    ST_SETTLE = 7'b000_0100,
    ST_NULL   = 7'b000_1000,
    ST_COARSE = 7'b001_0000,
    ST_FINE   = 7'b010_0000,
    ST_DONE   = 7'b100_0000
  } seq_state_t;

endpackage

// [rtl/afe_gain_decode.sv]
// Gain code decoder giving the gain times two
`timescale 1ns/1ps
module afe_gain_decode (
  // Configuration
  input  wire logic [2:0] i_gain_code_bits,
  input  wire logic       i_is_temp,
  // Decoded
  output logic      [8:0] o_gain_x2
);
  import afe_ctrl_pkg::*;

  always_comb begin
    if (i_is_temp) begin
      o_gain_x2 = 9'h00c; // R18
    end else begin
      case (i_gain_code_bits) // R4
        3'h0:    o_gain_x2 = 9'h003;
        3'h4:    o_gain_x2 = 9'h006;
        3'h1:    o_gain_x2 = 9'h00c;
        3'h5:    o_gain_x2 = 9'h018;
        3'h2:    o_gain_x2 = 9'h030;
        3'h6:    o_gain_x2 = 9'h060;
        3'h3:    o_gain_x2 = 9'h0c0;
        default: o_gain_x2 = 9'h180;
      endcase
    end
  end
endmodule

// [bench/afe_ctrl_chk.sv]
// Port assertions for the conversion sequencer
`timescale 1ns/1ps
module afe_ctrl_chk (
  // Clock, reset and register port
  input wire logic                            i_sys_clk,
  input wire logic                            i_rst_n,
  input wire logic                            i_cfg_wr,
  input wire logic                            i_cfg_rd,
  input wire logic [afe_ctrl_pkg::ADDR_W-1:0] i_cfg_addr,
  input wire logic [afe_ctrl_pkg::CFG_W-1:0]  i_cfg_wdata,
  input wire logic [afe_ctrl_pkg::CFG_W-1:0]  o_cfg_rdata,
  // Modes and request
  input wire logic                            i_two_wire,
  input wire logic                            i_calib_mode,
  input wire logic                            i_start,
  // Sequencer outputs
  input wire logic                            o_null_en,
  input wire logic                            o_integrate,
  input wire logic                            o_fine_en,
  input wire logic                            o_bridge_sink_on,
  input wire logic                            o_four_wire_en,
  input wire logic signed [afe_ctrl_pkg::RES_W:0] o_result,
  input wire logic [8:0]                      o_gain_x2,
  input wire logic                            o_result_temp,
  input wire logic                            o_result_valid,
  input wire logic                            o_busy
);
  import afe_ctrl_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_wr_bridge;
    i_cfg_wr && i_cfg_addr == BRIDGE_CFG_ADDR;
  endsequence
  sequence s_rd_bridge;
    i_cfg_rd && !i_cfg_wr && i_cfg_addr == BRIDGE_CFG_ADDR;
  endsequence
  sequence s_settle;
    !(o_null_en || o_integrate) [*8];
  endsequence
  AST_READBACK: assert property (
    s_wr_bridge ##1 s_rd_bridge |=> o_cfg_rdata == $past(i_cfg_wdata, 2))
    else $error("bridge word read back wrong");
  AST_SETTLE: assert property (
    $rose(o_bridge_sink_on) |-> s_settle)
    else $error("conversion began without settling");
  AST_SINK_CONV: assert property (
    (o_integrate || o_fine_en) |-> o_bridge_sink_on)
    else $error("converting with sink off");
  AST_SINK_OFF: assert property (
    o_result_valid |-> !o_bridge_sink_on)
    else $error("sink still on at result");
  AST_VALID_PULSE: assert property (
    o_result_valid |=> !o_result_valid)
    else $error("result valid longer than one cycle");
  AST_VALID_BUSY: assert property (
    o_result_valid |-> $past(o_busy))
    else $error("result without a measurement");
  AST_BUSY_START: assert property (
    $rose(o_busy) |-> $past(i_start, 2))
    else $error("busy without start");
  AST_PHASES: assert property (
    !(o_integrate && o_fine_en) && !(o_null_en && o_integrate))
    else $error("phases overlap");
  AST_FINE_AFTER: assert property (
    $rose(o_fine_en) |-> $past(o_integrate))
    else $error("fine step not after coarse");
  AST_TEMP_GAIN: assert property (
    o_result_valid && o_result_temp |-> o_gain_x2 == 9'h00c)
    else $error("temperature gain not six");
  AST_RESULT_HOLD: assert property (
    !o_result_valid |-> $stable(o_result))
    else $error("result changed without valid");
  AST_FOUR_WIRE: assert property (
    $past(i_two_wire || i_calib_mode) |-> !o_four_wire_en)
    else $error("four-wire enabled wrongly");
endmodule
bind afe_config_adc_control afe_ctrl_chk chk (.*);

// [bench/bridge_front_model.sv]
// Behavioural bridge and preamplifier giving the comparator bit
`timescale 1ns/1ps
module bridge_front_model (
  // Clock and phases from the block
  input  wire logic i_sys_clk,
  input  wire logic i_input_short,
  input  wire logic i_integrate,
  input  wire logic i_fine_en,
  // Input level set by the bench
  input  wire logic i_level,
  // Comparator bit
  output logic      o_adc_bit
);
  // Shorted input reads full scale; the bridge level stands otherwise,
  // since the phase outputs lag the sampling state by one cycle
  always_comb begin
    if (i_input_short) begin
      o_adc_bit = 1'b1;
    end else begin
      o_adc_bit = i_level;
    end
  end
endmodule

// [bench/afe_config_adc_control_test.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module afe_config_adc_control_test;
  import afe_ctrl_pkg::*;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_adc_bit;
  logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_start = 1'b0;
  logic i_fast_clk = 1'b1, i_two_wire = 1'b1, i_calib_mode = 1'b0;
  logic i_temp_sel = 1'b0, lvl = 1'b1;
  logic [ADDR_W-1:0] i_cfg_addr = '0;
  logic [CFG_W-1:0] i_cfg_wdata = '0, o_cfg_rdata;
  logic [2:0] o_amp_gain_code, cg;
  logic [3:0] o_range_shift_code, cs;
  logic o_chop_phase, o_null_en, o_integrate, o_fine_en, o_input_short;
  logic o_bridge_sink_on, o_four_wire_en, o_result_temp;
  logic o_result_valid, o_busy, cp, saw_null, saw_short, act;
  logic signed [RES_W:0] o_result, ez;
  logic [RES_W-1:0] o_zero_count;
  logic [8:0] o_gain_x2;
  int fails = 0, compares = 0, int_cyc, settle;
  afe_config_adc_control #(.CHOP_TICKS_P(2), .NULL_TICKS_P(2),
    .AZ_EVERY_P(2)) uut (.*);
  bridge_front_model model (.i_sys_clk, .i_input_short(o_input_short),
    .i_integrate(o_integrate), .i_fine_en(o_fine_en), .i_level(lvl),
    .o_adc_bit(i_adc_bit));
  initial begin
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic check_val(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t value %h exp %h", $time, got, e);
    end
  endtask
  task automatic check_flag(input logic got, input logic e);
    compares++;
    if (got !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, e);
    end
  endtask
  task automatic cfg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
  endtask
  task automatic cfg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b0;
    i_cfg_rd <= 1'b1;
    i_cfg_addr <= a;
    @(posedge i_sys_clk);
    i_cfg_rd <= 1'b0;
    @(posedge i_sys_clk);
    #1 d = o_cfg_rdata;
  endtask
  task automatic run_meas(input logic t);
    int n;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'b0;
    i_start <= 1'b1;
    i_temp_sel <= t;
    @(posedge i_sys_clk);
    i_start <= 1'b0;
    {int_cyc, settle, saw_null, saw_short, act} = '0;
    for (n = 0; n < 8000 && o_result_valid !== 1'b1; n++) begin
      @(posedge i_sys_clk);
      #1;
      saw_null |= o_null_en;
      saw_short |= o_input_short;
      if (o_integrate && !o_input_short) begin
        int_cyc++;
        {cg, cs, cp} = {o_amp_gain_code, o_range_shift_code, o_chop_phase};
      end
      act |= o_null_en | o_integrate;
      if (o_bridge_sink_on && !act) settle++;
    end
    check_flag(o_result_valid, 1'b1);
  endtask
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    fails++;
    complete_run();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    logic [15:0] rd, w;
    logic [2:0] g;
    int norm;
    logic [8:0] gx2 [8] = '{9'h003, 9'h00c, 9'h030, 9'h0c0, 9'h006,
      9'h018, 9'h060, 9'h180};
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    cfg_read(BRIDGE_CFG_ADDR, rd);
    check_val(rd, BRIDGE_CFG_RST);
    cfg_read(TEMP_CFG_ADDR, rd);
    check_val(rd, TEMP_CFG_RST);
    cfg_write(5'h00, 16'hffff);
    cfg_read(5'h00, rd);
    check_val(rd, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      g = k[2:0];
      w = {3'h7, g == 3'h0 || g == 3'h4, 4'h0, g[0], g, 1'b1, g};
      cfg_write(BRIDGE_CFG_ADDR, w);
      cfg_read(BRIDGE_CFG_ADDR, rd);
      check_val(rd, w);
      run_meas(1'b0);
      check_val(cg, g);
      check_val(o_gain_x2, gx2[k]);
      check_val(cs, {1'b1, g});
      check_flag(cp, ~g[0]);
      check_flag(saw_null, !w[12]);
      check_val(o_result, 32'h0);
      check_flag(settle >= SETTLE_4MHZ_CYC, 1'b1);
      norm = int_cyc;
    end
    cfg_write(BRIDGE_CFG_ADDR, 16'h0198);
    run_meas(1'b0);
    run_meas(1'b0);
    check_val(int_cyc, 4 * norm);
    cfg_write(BRIDGE_CFG_ADDR, 16'h0098);
    lvl <= 1'b0;
    repeat (2) begin
      run_meas(1'b0);
      if (saw_short) break;
    end
    ez = '0 - {1'b0, o_zero_count};
    check_flag(saw_short, 1'b1);
    check_flag(o_zero_count != '0, 1'b1);
    check_val(o_result, ez);
    lvl <= 1'b1;
    run_meas(1'b1);
    check_flag(o_result_temp, 1'b1);
    check_val(o_gain_x2, 9'h00c);
    check_val(cg, TEMP_CFG_RST[6:4]);
    @(posedge i_sys_clk);
    i_fast_clk <= 1'b0;
    run_meas(1'b0);
    check_flag(settle >= SETTLE_1MHZ_CYC, 1'b1);
    for (int m = 0; m < 4; m++) begin
      @(posedge i_sys_clk);
      {i_calib_mode, i_two_wire} <= m[1:0];
      repeat (2) @(posedge i_sys_clk);
      #1 check_flag(o_four_wire_en, m == 0);
    end
    complete_run();
  end
endmodule
